/* File: rtl/tasg_map.svh */
/*
  Register indexes, field positions, reset values and timing figures of the
  port time-aware shaper gate. Assumes inclusion by bare name.
*/
`ifndef TASG_MAP_SVH
`define TASG_MAP_SVH

// Register indexes, byte address is four times the index
`define TASG_IDX_CTRL        12'h920
`define TASG_IDX_EVIDX       12'h923
`define TASG_IDX_EVENT       12'h924
`define TASG_IDX_QCTRL       12'h930
`define TASG_IDX_REFTIME     12'h931
`define TASG_IDX_STATUS      12'h932

// Field positions
`define TASG_CTRL_CUT        7
`define TASG_CTRL_RESTRICT   6
`define TASG_QCTRL_MODE_LO   4
`define TASG_EV_CODE_LO      29

// Reset values
`define TASG_CTRL_RST        8'h00
`define TASG_EVIDX_RST       7'h00
`define TASG_QCTRL_RST       2'h0
`define TASG_EVENT_RST       32'h0000_0000

// Shaper mode that hands egress to the schedule
`define TASG_MODE_TAS        2'h2

// Timing
`define TASG_CLK_PERIOD_NS   100
`define TASG_ONE_SEC_NS      1000000000
`define TASG_ONE_SEC_CYC     (`TASG_ONE_SEC_NS / `TASG_CLK_PERIOD_NS)

`endif

/* File: rtl/tasg_pkg.sv */
/*
  Types of the port time-aware shaper gate.
  Assumes nothing of its surroundings.
*/
package tasg_pkg;

  // Gate event codes, the rest are reserved
  typedef enum logic [2:0] {
    TASG_EV_CLOSE  = 3'b000,
    TASG_EV_GUARD  = 3'b001,
    TASG_EV_OPEN   = 3'b010,
    TASG_EV_REPEAT = 3'b111
  } tasg_ev_e;

  // Cycle origin reference selection
  typedef enum logic [1:0] {
    TASG_REF_NONE = 2'b00,
    TASG_REF_FREE = 2'b01,
    TASG_REF_PPS  = 2'b10,
    TASG_REF_TIME = 2'b11
  } tasg_ref_e;

  // One gate event list entry
  typedef struct packed {
    logic [2:0]  code;
    logic [28:0] time_v;
  } tasg_entry_s;

  // Gate state handed to the egress scheduler
  typedef struct packed {
    logic tx_allow;
    logic cut_through;
    logic guard_band;
    logic gate_open;
  } tasg_gate_s;

endpackage

/* File: rtl/tasg_gate.sv */
/*
  Per-port egress time-aware shaper gate with a classic Wishbone slave.
  Assumes a 10 MHz system clock, a PTP pulse-per-second pin from outside the
  clock domain and a PTP time word from logic on the same clock.
*/
`timescale 1ns/1ns
`include "tasg_map.svh"

// How it works
// R1 - Control bit seven enables shaper cut-through
// R2 - Restricted bit holds shaped traffic until open
// R3 - Select 11 starts origin once time reaches reference time
// R4 - Select 10 uses pps, 01 internal second
// R5 - Seven-bit event index, bit seven reads zero
// R6 - Three-bit event code in top bits
// R7 - Twenty-nine bit event time in clock cycles
// R8 - Schedule governs only in shaper mode 10
// R9 - Entry register follows index, walk restarts at repeat
module tasg_gate
  import tasg_pkg::*;
#(
  parameter int unsigned ONE_SEC_CYC = `TASG_ONE_SEC_CYC,
  parameter int unsigned NUM_EVENTS  = 128
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [13:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        pps_i,
  input  wire logic [31:0] ptp_time_i,
  output tasg_gate_s       gate_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset and pin synchronisers

  logic        rst_meta_q;
  logic        rst_n_q;
  logic        pps_meta_q;
  logic        pps_sync_q;
  logic        pps_prev_q;
  logic        pps_rise;

  // Reset release through two flops
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Pulse-per-second pin synchroniser and edge
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pps_meta_q <= 1'b0;
      pps_sync_q <= 1'b0;
      pps_prev_q <= 1'b0;
    end else begin
      pps_meta_q <= pps_i;
      pps_sync_q <= pps_meta_q;
      pps_prev_q <= pps_sync_q;
    end
  end

  assign pps_rise = pps_sync_q & ~pps_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0]  ctrl_q;
  logic [6:0]  ev_idx_q;
  logic [1:0]  mode_q;
  logic [31:0] ref_time_q;
  logic [31:0] ev_mem_q [NUM_EVENTS];
  logic        ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_d;
  logic        req;
  logic        wr;
  logic [11:0] idx;
  tasg_ref_e   ref_sel;

  assign req     = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr      = req & wb_we_i;
  assign idx     = wb_adr_i[13:2];
  assign ref_sel = tasg_ref_e'(ctrl_q[1:0]);

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Control, index, mode and reference time writes
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q     <= `TASG_CTRL_RST;
      ev_idx_q   <= `TASG_EVIDX_RST;
      mode_q     <= `TASG_QCTRL_RST;
      ref_time_q <= 32'h0000_0000;
    end else if (wr && wb_sel_i[0]) begin
      unique case (idx)
        `TASG_IDX_CTRL:    ctrl_q <= {wb_dat_i[7:6], 4'h0, wb_dat_i[1:0]};  // R1
        `TASG_IDX_EVIDX:   ev_idx_q <= wb_dat_i[6:0];                       // R5
        `TASG_IDX_QCTRL:   mode_q <= wb_dat_i[`TASG_QCTRL_MODE_LO +: 2];
        `TASG_IDX_REFTIME: ref_time_q <= merge(ref_time_q, wb_dat_i, wb_sel_i);
        default:           ;
      endcase
    end else if (wr && idx == `TASG_IDX_REFTIME) begin
      ref_time_q <= merge(ref_time_q, wb_dat_i, wb_sel_i);
    end
  end

  // Event list entry chosen by the index
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < NUM_EVENTS; i++) begin
        ev_mem_q[i] <= `TASG_EVENT_RST;                                     // R7
      end
    end else if (wr && idx == `TASG_IDX_EVENT) begin
      ev_mem_q[ev_idx_q] <= merge(ev_mem_q[ev_idx_q], wb_dat_i, wb_sel_i); // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Schedule walk

  logic        running_q;
  logic        armed_q;
  logic [28:0] cyc_q;
  logic [6:0]  ptr_q;
  logic        open_q;
  logic        guard_q;
  logic [31:0] sec_cnt_q;
  logic        sec_tick_q;
  logic        origin;
  logic        hit;
  tasg_entry_s cur;

  assign cur = tasg_entry_s'(ev_mem_q[ptr_q]);
  assign hit = running_q && (cur.time_v == cyc_q);                         // R7

  // Origin from the selected reference
  always_comb begin
    unique case (ref_sel)
      TASG_REF_TIME: origin = armed_q && (ptp_time_i >= ref_time_q);       // R3
      TASG_REF_PPS:  origin = pps_rise;                                    // R4
      TASG_REF_FREE: origin = sec_tick_q;                                  // R4
      TASG_REF_NONE: origin = 1'b0;                                        // R3
    endcase
  end

  // Internal one-second divider
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sec_cnt_q  <= 32'h0000_0000;
      sec_tick_q <= 1'b0;
    end else begin
      sec_tick_q <= (sec_cnt_q == ONE_SEC_CYC - 1);
      sec_cnt_q  <= (sec_cnt_q == ONE_SEC_CYC - 1) ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
    end
  end

  // Reference time arming, once per control write
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      armed_q <= 1'b0;
    end else if (wr && wb_sel_i[0] && idx == `TASG_IDX_CTRL) begin
      armed_q <= (wb_dat_i[1:0] == TASG_REF_TIME);                         // R3
    end else if (origin && ref_sel == TASG_REF_TIME) begin
      armed_q <= 1'b0;
    end
  end

  // Cycle counter and event pointer
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      running_q <= 1'b0;
      cyc_q     <= 29'h0000_0000;
      ptr_q     <= 7'h00;
    end else if (ref_sel == TASG_REF_NONE) begin
      running_q <= 1'b0;
    end else if (origin) begin
      running_q <= 1'b1;
      cyc_q     <= 29'h0000_0000;
      ptr_q     <= 7'h00;
    end else if (running_q) begin
      if (hit && cur.code == TASG_EV_REPEAT) begin
        cyc_q <= 29'h0000_0000;                                             // R9
        ptr_q <= 7'h00;
      end else begin
        cyc_q <= cyc_q + 29'h0000_0001;
        if (hit) begin
          ptr_q <= ptr_q + 7'h01;                                           // R9
        end
      end
    end
  end

  // Gate state from the event codes
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      open_q  <= 1'b0;
      guard_q <= 1'b0;
    end else if (origin) begin
      open_q  <= 1'b0;
      guard_q <= 1'b0;
    end else if (hit) begin
      unique case (cur.code)                                                // R6
        TASG_EV_OPEN: begin
          open_q  <= 1'b1;
          guard_q <= 1'b0;
        end
        TASG_EV_CLOSE: begin
          open_q  <= 1'b0;
          guard_q <= 1'b0;
        end
        TASG_EV_GUARD: guard_q <= 1'b1;
        default:       ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and bus answer

  // Read multiplexer, unmapped reads give zero
  always_comb begin
    unique case (idx)
      `TASG_IDX_CTRL:    rd_d = {24'h00_0000, ctrl_q};
      `TASG_IDX_EVIDX:   rd_d = {25'h000_0000, ev_idx_q};                  // R5
      `TASG_IDX_EVENT:   rd_d = ev_mem_q[ev_idx_q];                        // R9
      `TASG_IDX_QCTRL:   rd_d = {26'h000_0000, mode_q, 4'h0};
      `TASG_IDX_REFTIME: rd_d = ref_time_q;
      `TASG_IDX_STATUS:  rd_d = {running_q, open_q, guard_q, cyc_q};
      default:           rd_d = 32'h0000_0000;
    endcase
  end

  // Bus answer one cycle after the request
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      dat_q <= req ? rd_d : 32'h0000_0000;
    end
  end

  // Gate outputs to the egress scheduler
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gate_o <= '0;
    end else begin
      gate_o.cut_through <= ctrl_q[`TASG_CTRL_CUT];                         // R1
      gate_o.gate_open   <= open_q;
      gate_o.guard_band  <= guard_q;
      gate_o.tx_allow    <= (mode_q != `TASG_MODE_TAS)                      // R8
                            || !ctrl_q[`TASG_CTRL_RESTRICT] || open_q;      // R2
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_q);

  property p_cut;
    ctrl_q[`TASG_CTRL_CUT] ##1 ctrl_q[`TASG_CTRL_CUT] |-> gate_o.cut_through;
  endproperty
  a_cut: assert property (p_cut) else $error("cut-through output not following control"); // R1

  property p_restrict;
    mode_q == `TASG_MODE_TAS && ctrl_q[`TASG_CTRL_RESTRICT] && !open_q |=> !gate_o.tx_allow;
  endproperty
  a_restrict: assert property (p_restrict) else $error("shaped traffic allowed while gate closed"); // R2

  property p_ref_time;
    ref_sel == TASG_REF_TIME && armed_q && ptp_time_i >= ref_time_q |=> running_q && cyc_q == 29'h0 && !armed_q;
  endproperty
  a_ref_time: assert property (p_ref_time) else $error("origin not started at reference time"); // R3

  property p_pps;
    ref_sel == TASG_REF_PPS && pps_rise |=> cyc_q == 29'h0 && ptr_q == 7'h00;
  endproperty
  a_pps: assert property (p_pps) else $error("origin not restarted on pulse per second"); // R4

  property p_idx_read;
    wb_ack_o && $past(idx) == `TASG_IDX_EVIDX |-> wb_dat_o[31:7] == 25'h0 && wb_dat_o[6:0] == $past(ev_idx_q);
  endproperty
  a_idx_read: assert property (p_idx_read) else $error("index read wrong"); // R5

  property p_open;
    hit && cur.code == TASG_EV_OPEN && !origin |=> open_q ##1 gate_o.gate_open;
  endproperty
  a_open: assert property (p_open) else $error("open event did not open the gate"); // R6

  property p_count;
    running_q && !origin && !hit && ref_sel != TASG_REF_NONE |=> cyc_q == $past(cyc_q) + 29'h1;
  endproperty
  a_count: assert property (p_count) else $error("cycle counter did not advance"); // R7

  property p_mode;
    mode_q != `TASG_MODE_TAS |=> gate_o.tx_allow;
  endproperty
  a_mode: assert property (p_mode) else $error("egress held outside shaper mode"); // R8

  property p_repeat;
    hit && cur.code == TASG_EV_REPEAT && ref_sel != TASG_REF_NONE |=> ptr_q == 7'h00 && cyc_q == 29'h0;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat event did not restart the walk"); // R9

endmodule

/* File: verification/tasg_egress_model.sv */
/*
  Egress scheduler and transmit MAC model facing the shaper gate.
  Assumes one shaped frame is always queued and the gate struct is registered.
*/
`timescale 1ns/1ns

module tasg_egress_model
  import tasg_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire tasg_gate_s  gate_i,
  output logic [31:0]      tx_cycles_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Shaped traffic leaves only while the gate allows it
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_cycles_o <= 32'h0000_0000;
    end else if (gate_i.tx_allow) begin
      tx_cycles_o <= tx_cycles_o + 32'h0000_0001;
    end
  end

endmodule

/* File: verification/tasg_gate_bench.sv */
/*
  Self-checking bench of the shaper gate: register tasks and gate timing.
  Assumes the design answers each Wishbone request one cycle after taking it.
*/
`timescale 1ns/1ns
`include "tasg_map.svh"

module tasg_gate_bench
  import tasg_pkg::*;
;
  localparam int ONE_SEC = 50;

  logic        clock_i;
  logic        rst_n       = 1'b0;
  logic        wb_cyc      = 1'b0;
  logic        wb_stb      = 1'b0;
  logic        wb_we       = 1'b0;
  logic [13:0] wb_adr      = 14'h0000;
  logic [3:0]  wb_sel      = 4'h0;
  logic [31:0] wb_wdat     = 32'h0000_0000;
  logic        pps         = 1'b0;
  logic [31:0] ptp_time    = 32'h0000_0000;
  wire  [31:0] wb_rdat;
  wire         wb_ack;
  tasg_gate_s  gate;
  wire  [31:0] tx_cycles;
  logic [31:0] rd;
  logic [31:0] tx_mark;
  int          c;
  int          n_mismatch  = 0;
  int          total_checks = 0;
  // Open@5, guard@7, close@9, reserved no-op@11, repeat@12
  logic [31:0] ev [5] = '{32'h4000_0005, 32'h2000_0007, 32'h0000_0009, 32'h6000_000b, 32'he000_000c};

  ////////////////////////////////////////////////////////////////////////////
  // Design and far side
  tasg_gate #(.ONE_SEC_CYC(ONE_SEC)) u_tasg_gate (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n),
    .wb_cyc_i   (wb_cyc),
    .wb_stb_i   (wb_stb),
    .wb_we_i    (wb_we),
    .wb_adr_i   (wb_adr),
    .wb_sel_i   (wb_sel),
    .wb_dat_i   (wb_wdat),
    .wb_dat_o   (wb_rdat),
    .wb_ack_o   (wb_ack),
    .pps_i      (pps),
    .ptp_time_i (ptp_time),
    .gate_o     (gate)
  );

  tasg_egress_model u_tasg_egress_model (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n),
    .gate_i      (gate),
    .tx_cycles_o (tx_cycles)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and run end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic Wishbone cycle, read data lands in rd
  task automatic wb_xfer(input logic we, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= {idx, 2'b00};
    wb_sel  <= 4'hf;
    wb_wdat <= wd;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (wb_ack !== 1'b1) begin
      n_mismatch++;
      $display("ERROR bus ack timeout");
      stop_test();
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clock_i);
  endtask

  // Bounded wait for a gate bit to reach a level, cycles in c
  task automatic wait_bit(input int b, input logic lvl);
    c = 0;
    do begin
      @(posedge clock_i);
      c++;
    end while (gate[b] !== lvl && c < 200);
    if (gate[b] !== lvl) begin
      n_mismatch++;
      $display("ERROR gate wait timeout");
      stop_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge clock_i);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock_i);
    // Reset values
    wb_xfer(1'b0, `TASG_IDX_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    wb_xfer(1'b0, `TASG_IDX_EVIDX, 32'h0);
    check("index reset", rd, 32'h0);
    wb_xfer(1'b0, `TASG_IDX_EVENT, 32'h0);
    check("entry reset", rd, `TASG_EVENT_RST);
    check("tx_allow unshaped", gate.tx_allow, 1'b1);
    // Writable fields and reserved bits
    wb_xfer(1'b1, `TASG_IDX_CTRL, 32'hffff_fffc);
    wb_xfer(1'b0, `TASG_IDX_CTRL, 32'h0);
    check("ctrl fields", rd, 32'hc0);
    check("cut through on", gate.cut_through, 1'b1);
    wb_xfer(1'b1, `TASG_IDX_CTRL, 32'h0);
    check("cut through off", gate.cut_through, 1'b0);
    wb_xfer(1'b1, `TASG_IDX_EVIDX, 32'hffff_ffff);
    wb_xfer(1'b0, `TASG_IDX_EVIDX, 32'h0);
    check("index width", rd, 32'h7f);
    wb_xfer(1'b1, 12'h925, 32'hffff_ffff);
    wb_xfer(1'b0, 12'h925, 32'h0);
    check("unmapped", rd, 32'h0);
    // Event list through the index
    for (int i = 0; i < 5; i++) begin
      wb_xfer(1'b1, `TASG_IDX_EVIDX, i);
      wb_xfer(1'b1, `TASG_IDX_EVENT, ev[i]);
    end
    wb_xfer(1'b1, `TASG_IDX_EVIDX, 32'h1);
    wb_xfer(1'b0, `TASG_IDX_EVENT, 32'h0);
    check("entry readback", rd, ev[1]);
    // Restricted schedule, internal second
    wb_xfer(1'b1, `TASG_IDX_QCTRL, 32'h20);
    wb_xfer(1'b1, `TASG_IDX_CTRL, 32'h41);
    wait_bit(0, 1'b1);
    wait_bit(1, 1'b1);
    check("open to guard", c, 2);
    check("guard keeps open", gate.gate_open, 1'b1);
    wait_bit(0, 1'b0);
    check("guard to close", c, 2);
    check("close clears guard", gate.guard_band, 1'b0);
    repeat (2) @(posedge clock_i);
    check("held when closed", gate.tx_allow, 1'b0);
    tx_mark = tx_cycles;
    wait_bit(0, 1'b1);
    // Nine cycles from close to open, two of them spent above
    check("close to open", c, 7);
    check("no egress closed", tx_cycles, tx_mark);
    repeat (2) @(posedge clock_i);
    check("allowed when open", gate.tx_allow, 1'b1);
    // Unrestricted, then schedule out of shaper mode
    wb_xfer(1'b1, `TASG_IDX_CTRL, 32'h01);
    wait_bit(0, 1'b0);
    repeat (2) @(posedge clock_i);
    check("unrestricted", gate.tx_allow, 1'b1);
    wb_xfer(1'b1, `TASG_IDX_CTRL, 32'h41);
    wb_xfer(1'b1, `TASG_IDX_QCTRL, 32'h00);
    wait_bit(0, 1'b0);
    repeat (2) @(posedge clock_i);
    check("mode not shaper", gate.tx_allow, 1'b1);
    wb_xfer(1'b1, `TASG_IDX_QCTRL, 32'h20);
    // Pulse-per-second origin, walk stopped right after a close so the frozen gate is shut
    wait_bit(0, 1'b1);
    wait_bit(0, 1'b0);
    wb_xfer(1'b1, `TASG_IDX_CTRL, 32'h40);
    wb_xfer(1'b1, `TASG_IDX_CTRL, 32'h42);
    repeat (20) @(posedge clock_i);
    check("waits for pps", gate.gate_open, 1'b0);
    pps <= 1'b1;
    repeat (2) @(posedge clock_i);
    pps <= 1'b0;
    wait_bit(0, 1'b1);
    check("pps origin", c < 20, 1'b1);
    // Reference time origin
    wait_bit(0, 1'b0);
    wb_xfer(1'b1, `TASG_IDX_CTRL, 32'h40);
    wb_xfer(1'b1, `TASG_IDX_REFTIME, 32'd100);
    wb_xfer(1'b1, `TASG_IDX_CTRL, 32'h43);
    repeat (20) @(posedge clock_i);
    check("before reference", gate.gate_open, 1'b0);
    ptp_time <= 32'd100;
    wait_bit(0, 1'b1);
    check("reference crossed", c < 20, 1'b1);
    // Status mid-walk: running, open, guard band, count eight
    wb_xfer(1'b0, `TASG_IDX_STATUS, 32'h0);
    check("status", rd, 32'he000_0008);
    stop_test();
  end

endmodule
